// ---- hdl/wrap_pkg.sv ----
// constants, types and register map of the wrap coordinate generator
// assumes one 20 MHz clock, synchronous active-high reset
package wrap_pkg;
   localparam logic [7:0]  ADDR_MODE     = 8'h00;
   localparam logic [7:0]  ADDR_SRC      = 8'h04;
   localparam logic [7:0]  ADDR_EN       = 8'h08;
   localparam logic [7:0]  ADDR_RANGE    = 8'h0c;
   localparam logic [7:0]  ADDR_RATIO    = 8'h10;
   localparam logic [7:0]  ADDR_OFFSET   = 8'h14;
   localparam logic [7:0]  ADDR_GEAR_A   = 8'h18;
   localparam logic [7:0]  ADDR_GEAR_B   = 8'h1c;
   localparam logic [7:0]  ADDR_HOME     = 8'h20;
   localparam logic [7:0]  ADDR_CMD      = 8'h24;
   localparam logic [7:0]  ADDR_STATUS   = 8'h28;
   localparam logic [7:0]  ADDR_INT_STAT = 8'h2c;
   localparam logic [7:0]  ADDR_INT_EN   = 8'h30;
   localparam logic [7:0]  ADDR_INT_CLR  = 8'h34;
   localparam logic [7:0]  ADDR_CMD_POS  = 8'h38;
   localparam logic [7:0]  ADDR_ACT_POS  = 8'h3c;
   localparam int          CMD_CONFIG    = 0;
   localparam int          CMD_PRESET    = 1;
   localparam logic [14:0] RANGE_RST     = 15'h000a;
   localparam logic [13:0] RATIO_RST     = 14'h1388;
   localparam logic [13:0] RATIO_MAX     = 14'h2710;
   localparam logic [29:0] OFFSET_RST    = 30'h00000000;
   localparam logic [15:0] GEAR_RST      = 16'h0001;
   localparam logic [14:0] FULL_TENTHS   = 15'h4650;
   localparam logic [14:0] SMALL_TENTHS  = 15'h2328;
   localparam logic [47:0] STEPS_TENTH   = 48'h0000000003e8;
   localparam logic [47:0] RATIO_SCALE   = 48'h000000002710;
   localparam int          INT_W         = 4;
   localparam int          INT_INFO      = 0;
   localparam int          INT_ALARM     = 1;
   localparam int          INT_WRAP      = 2;
   localparam int          INT_PRESET    = 3;

   typedef enum logic [1:0] {
      MODE_ABS  = 2'b00,
      MODE_NEAR = 2'b01,
      MODE_FWD  = 2'b10,
      MODE_REV  = 2'b11
   } wrap_mode_t;

   typedef struct packed {
      logic        en;
      logic [14:0] range_tenths;
      logic [13:0] ratio;
      logic [29:0] offset;
   } wrap_cfg_t;

   typedef struct packed {
      logic       push;
      wrap_mode_t mode;
   } move_type_t;
endpackage

// ---- hdl/wrap_coordinate_generator.sv ----
// wrap coordinate generator: settings, validity checks, wrapping position counters
// assumes step pulses and sensor settings come from logic on clk
`timescale 1ns/10ps
module wrap_coordinate_generator
   import wrap_pkg::*;
#(
   parameter int POS_W = 32
)
(
   input  wire logic              clk,
   input  wire logic              rst,
   input  wire logic              ce,
   input  wire logic [7:0]        addr,
   input  wire logic [31:0]       wr_data,
   input  wire logic              wr_en,
   input  wire logic              rd_en,
   output logic [31:0]            rd_data,
   input  wire wrap_cfg_t         sensor_cfg,
   input  wire logic              small_frame,
   input  wire logic              push_sel,
   input  wire logic [1:0]        step_up,
   input  wire logic [1:0]        step_dn,
   output logic [POS_W-1:0]       cmd_pos,
   output logic [POS_W-1:0]       act_pos,
   output move_type_t             move_type,
   output logic                   wrap_active,
   output logic                   info_flag,
   output logic                   alarm,
   output logic                   home_set,
   output logic                   irq
);
   wrap_mode_t        mode_reg, mode_next;
   logic              src_reg, src_next, en_reg, en_next;
   logic [14:0]       range_reg, range_next;
   logic [13:0]       ratio_reg, ratio_next;
   logic [29:0]       offset_reg, offset_next;
   logic [15:0]       ga_reg, ga_next, gb_reg, gb_next;
   logic [31:0]       home_reg, home_next;
   wrap_cfg_t         app_reg, app_next;
   logic [15:0]       aga_reg, aga_next, agb_reg, agb_next;
   logic              boot_reg, chk_reg, chk_next;
   logic              info_reg, info_next, alarm_reg, alarm_next, hs_reg, hs_next;
   logic              act_reg, act_next, irq_reg, irq_next;
   logic [INT_W-1:0]  ist_reg, ist_next, ien_reg, ien_next, ev;
   logic [31:0]       rd_reg, rd_next;
   move_type_t        mt_reg, mt_next;
   logic              apply, preset;
   logic [47:0]       prod, span, ga_safe, rng_safe;
   logic signed [47:0] lower, upper;
   logic              c1, c2, home_out, info_now;
   logic [14:0]       full;
   logic [POS_W-1:0]  pos_reg [2];
   logic [1:0]        wrapped;

   assign apply  = boot_reg | (wr_en & addr == ADDR_CMD & wr_data[CMD_CONFIG]);
   assign preset = wr_en & addr == ADDR_CMD & wr_data[CMD_PRESET];

   // validity and bounds from applied settings
   always_comb
   begin
      full     = small_frame ? SMALL_TENTHS : FULL_TENTHS;
      rng_safe = (app_reg.range_tenths == 15'h0000) ? 48'h1 : {33'h0, app_reg.range_tenths};
      ga_safe  = (aga_reg == 16'h0000) ? 48'h1 : {32'h0, aga_reg};
      prod     = {33'h0, app_reg.range_tenths} * {32'h0, agb_reg} * STEPS_TENTH;
      c1       = app_reg.range_tenths != 15'h0000 && ({33'h0, full} % rng_safe) == 48'h0;
      c2       = aga_reg != 16'h0000 && (prod % ga_safe) == 48'h0;
      span     = prod / ga_safe;
      lower    = 48'(signed'(app_reg.offset)) - 48'((64'(span) * 64'(app_reg.ratio)) / 64'(RATIO_SCALE));
      upper    = lower + signed'(span) - 48'sd1;
      home_out = 48'(signed'(home_reg)) < lower || 48'(signed'(home_reg)) > upper;
      info_now = app_reg.en & (~c1 | ~c2 | home_out);
   end

   // register file, apply, flags and interrupts
   always_comb
   begin
      mode_next   = mode_reg;
      src_next    = src_reg;
      en_next     = en_reg;
      range_next  = range_reg;
      ratio_next  = ratio_reg;
      offset_next = offset_reg;
      ga_next     = ga_reg;
      gb_next     = gb_reg;
      home_next   = home_reg;
      ien_next    = ien_reg;
      app_next    = app_reg;
      aga_next    = aga_reg;
      agb_next    = agb_reg;
      if (wr_en)
      begin
         unique case (addr)
            ADDR_MODE:   mode_next = wrap_mode_t'(wr_data[1:0]);
            ADDR_SRC:    src_next = wr_data[0];
            ADDR_EN:     en_next = wr_data[0];
            ADDR_RANGE:  range_next = wr_data[14:0];
            ADDR_RATIO:  ratio_next = (wr_data > 32'(RATIO_MAX)) ? RATIO_MAX : wr_data[13:0];
            ADDR_OFFSET: offset_next = wr_data[29:0];
            ADDR_GEAR_A: ga_next = wr_data[15:0];
            ADDR_GEAR_B: gb_next = wr_data[15:0];
            ADDR_HOME:   home_next = wr_data;
            ADDR_INT_EN: ien_next = wr_data[INT_W-1:0];
            default:     ;
         endcase
      end
      if (apply)
      begin
         app_next = src_reg ? {en_reg, range_reg, ratio_reg, offset_reg} : sensor_cfg;
         aga_next = ga_reg;
         agb_next = gb_reg;
      end
      chk_next   = apply;
      info_next  = info_now;
      alarm_next = alarm_reg;
      if (chk_reg)
         alarm_next = info_now;
      act_next   = app_reg.en & c1 & c2;
      mt_next    = '{push: push_sel, mode: mode_reg};
      hs_next    = hs_reg | preset;
      ev         = {preset, wrapped[0], chk_reg & info_now, info_now & ~info_reg};
      ist_next   = ist_reg;
      if (wr_en && addr == ADDR_INT_CLR)
         ist_next = ist_reg & ~wr_data[INT_W-1:0];
      ist_next   = ist_next | ev;
      irq_next   = |(ist_next & ien_reg);
      rd_next    = 32'h0;
      if (rd_en)
      begin
         unique case (addr)
            ADDR_MODE:     rd_next = {30'h0, mode_reg};
            ADDR_SRC:      rd_next = {31'h0, src_reg};
            ADDR_EN:       rd_next = {31'h0, en_reg};
            ADDR_RANGE:    rd_next = {17'h0, range_reg};
            ADDR_RATIO:    rd_next = {18'h0, ratio_reg};
            ADDR_OFFSET:   rd_next = {{2{offset_reg[29]}}, offset_reg};
            ADDR_GEAR_A:   rd_next = {16'h0, ga_reg};
            ADDR_GEAR_B:   rd_next = {16'h0, gb_reg};
            ADDR_HOME:     rd_next = home_reg;
            ADDR_STATUS:   rd_next = {28'h0, act_reg, hs_reg, alarm_reg, info_reg};
            ADDR_INT_STAT: rd_next = {{(32-INT_W){1'b0}}, ist_reg};
            ADDR_INT_EN:   rd_next = {{(32-INT_W){1'b0}}, ien_reg};
            ADDR_CMD_POS:  rd_next = 32'(pos_reg[0]);
            ADDR_ACT_POS:  rd_next = 32'(pos_reg[1]);
            default:       rd_next = 32'h0;
         endcase
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         mode_reg   <= MODE_ABS;
         src_reg    <= 1'b0;
         en_reg     <= 1'b1;
         range_reg  <= RANGE_RST;
         ratio_reg  <= RATIO_RST;
         offset_reg <= OFFSET_RST;
         ga_reg     <= GEAR_RST;
         gb_reg     <= GEAR_RST;
         home_reg   <= 32'h0;
         app_reg    <= '{en: 1'b1, range_tenths: RANGE_RST, ratio: RATIO_RST, offset: OFFSET_RST};
         aga_reg    <= GEAR_RST;
         agb_reg    <= GEAR_RST;
         boot_reg   <= 1'b1;
         chk_reg    <= 1'b0;
         info_reg   <= 1'b0;
         alarm_reg  <= 1'b0;
         hs_reg     <= 1'b0;
         act_reg    <= 1'b0;
         mt_reg     <= '{push: 1'b0, mode: MODE_ABS};
         ist_reg    <= '0;
         ien_reg    <= '0;
         irq_reg    <= 1'b0;
         rd_reg     <= 32'h0;
      end
      else if (ce)
      begin
         mode_reg   <= mode_next;
         src_reg    <= src_next;
         en_reg     <= en_next;
         range_reg  <= range_next;
         ratio_reg  <= ratio_next;
         offset_reg <= offset_next;
         ga_reg     <= ga_next;
         gb_reg     <= gb_next;
         home_reg   <= home_next;
         app_reg    <= app_next;
         aga_reg    <= aga_next;
         agb_reg    <= agb_next;
         boot_reg   <= 1'b0;
         chk_reg    <= chk_next;
         info_reg   <= info_next;
         alarm_reg  <= alarm_next;
         hs_reg     <= hs_next;
         act_reg    <= act_next;
         mt_reg     <= mt_next;
         ist_reg    <= ist_next;
         ien_reg    <= ien_next;
         irq_reg    <= irq_next;
         rd_reg     <= rd_next;
      end
   end

   // position counters: 0 command, 1 actual
   for (genvar i = 0; i < 2; i++)
   begin : g_pos
      logic [POS_W-1:0] pos_next;
      logic             wr_i;
      always_comb
      begin
         pos_next = pos_reg[i];
         wr_i     = 1'b0;
         if (preset)
            pos_next = POS_W'(home_reg);
         else if (step_up[i] & ~step_dn[i])
         begin
            if (act_reg && 48'(signed'(pos_reg[i])) == upper)
            begin
               pos_next = POS_W'(lower);
               wr_i     = 1'b1;
            end
            else
               pos_next = pos_reg[i] + POS_W'(1);
         end
         else if (step_dn[i] & ~step_up[i])
         begin
            if (act_reg && 48'(signed'(pos_reg[i])) == lower)
            begin
               pos_next = POS_W'(upper);
               wr_i     = 1'b1;
            end
            else
               pos_next = pos_reg[i] - POS_W'(1);
         end
      end
      assign wrapped[i] = wr_i;
      always_ff @(posedge clk)
      begin
         if (rst)
            pos_reg[i] <= '0;
         else if (ce)
            pos_reg[i] <= pos_next;
      end
   end

   assign rd_data     = rd_reg;
   assign cmd_pos     = pos_reg[0];
   assign act_pos     = pos_reg[1];
   assign move_type   = mt_reg;
   assign wrap_active = act_reg;
   assign info_flag   = info_reg;
   assign alarm       = alarm_reg;
   assign home_set    = hs_reg;
   assign irq         = irq_reg;

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   sequence cfg_cmd_s;
      ce && wr_en && addr == ADDR_CMD && wr_data[CMD_CONFIG];
   endsequence
   sequence bad_after_s;
      ce && chk_reg && info_now;
   endsequence
   sequence good_after_s;
      ce && chk_reg && !info_now;
   endsequence

   mode_reset_a: assert property ($fell(rst) |-> mode_reg == MODE_ABS && en_reg)
      else $error("mode or enable reset value wrong");
   move_type_a: assert property (ce |=> move_type.mode == $past(mode_reg) && move_type.push == $past(push_sel))
      else $error("move type not following mode");
   src_apply_a: assert property (!rst && ce && apply && !src_reg |=> app_reg == $past(sensor_cfg))
      else $error("sensor settings not applied");
   ratio_clamp_a: assert property (ce && wr_en && addr == ADDR_RATIO && wr_data > 32'd10000 |=> ratio_reg == 14'd10000)
      else $error("ratio not clamped");
   alarm_raise_a: assert property (cfg_cmd_s ##1 bad_after_s |=> alarm_reg)
      else $error("alarm not raised");
   info_track_a: assert property (ce && app_reg.en && !c1 |=> info_reg)
      else $error("info flag missing");
   wrap_roll_a: assert property (ce && act_reg && !preset && step_up[0] && !step_dn[0]
                                 && 48'(signed'(pos_reg[0])) == upper |=> 48'(signed'(pos_reg[0])) == $past(lower))
      else $error("position did not roll over");
   no_wrap_a: assert property (ce && !act_reg && !preset && step_dn[0] && !step_up[0]
                               |=> pos_reg[0] == $past(pos_reg[0]) - POS_W'(1))
      else $error("wrapped while invalid");
   preset_load_a: assert property (ce && preset |=> cmd_pos == $past(home_reg) && act_pos == $past(home_reg) && home_set)
      else $error("preset load wrong");
   irq_out_a: assert property (ce && |(ist_reg & ien_reg) && !(wr_en && addr == ADDR_INT_CLR) |=> irq)
      else $error("interrupt not raised");
   alarm_clear_a: assert property (cfg_cmd_s ##1 good_after_s |=> !alarm_reg)
      else $error("alarm not cleared by clean apply");
   roll_down_a: assert property (ce && act_reg && !preset && step_dn[0] && !step_up[0]
                                 && 48'(signed'(pos_reg[0])) == lower |=> 48'(signed'(pos_reg[0])) == $past(upper))
      else $error("position did not roll under");
   home_out_a: assert property (ce && app_reg.en && home_out |=> info_flag)
      else $error("home outside range not flagged");
   bad_range_a: assert property (ce && !c2 |=> !wrap_active)
      else $error("wrap active with invalid range");
   wrap_event_a: assert property (ce && wrapped[0] |=> ist_reg[INT_WRAP])
      else $error("wrap event not recorded");
   preset_event_a: assert property (ce && preset |=> ist_reg[INT_PRESET])
      else $error("preset event not recorded");
   freeze_hold_a: assert property (!ce |=> mode_reg == $past(mode_reg) && cmd_pos == $past(cmd_pos))
      else $error("state changed while clock enable low");
endmodule

// ---- dv/motion_partner.sv ----
// model of the profile position sequencer and the absolute position sensor
// assumes the bench asks for one step at a time and holds dir and mask while busy
`timescale 1ns/10ps
module motion_partner
   import wrap_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       go,
   input  wire logic       dir,
   input  wire logic [1:0] mask,
   input  wire logic       slow,
   output logic [1:0]      step_up,
   output logic [1:0]      step_dn,
   output logic            busy,
   output wrap_cfg_t       sensor_cfg
);
   logic [1:0] cnt;
   // stored settings: a listed range usable on the full 1800 rev sensor
   assign sensor_cfg = '{en: 1'b1, range_tenths: FULL_TENTHS, ratio: RATIO_RST, offset: OFFSET_RST};
   // one-cycle step pulse, prompt or after a stall
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         busy    <= 1'b0;
         cnt     <= 2'h0;
         step_up <= 2'h0;
         step_dn <= 2'h0;
      end
      else
      begin
         step_up <= 2'h0;
         step_dn <= 2'h0;
         if (go)
         begin
            busy <= 1'b1;
            cnt  <= slow ? 2'h3 : 2'h0;
         end
         else if (busy && cnt == 2'h0)
         begin
            busy <= 1'b0;
            if (dir)
               step_up <= mask;
            else
               step_dn <= mask;
         end
         else if (busy)
            cnt <= cnt - 2'h1;
      end
   end
endmodule

// ---- dv/wrap_coordinate_generator_tb.sv ----
// self-checking bench of the wrap coordinate generator
// assumes the register map and timing of the design package
`timescale 1ns/10ps
module wrap_coordinate_generator_tb;
   import wrap_pkg::*;
   logic        clk = 1'b0, rst = 1'b1, ce = 1'b1, wr_en = 1'b0, rd_en = 1'b0, rd_seen = 1'b0;
   logic        small_frame = 1'b0, push_sel = 1'b0, go = 1'b0, dir = 1'b0, slow = 1'b0;
   logic [7:0]  addr = 8'h00;
   logic [31:0] wr_data = 32'h0, seed = 32'd33910, rd_data, cmd_pos, act_pos;
   logic [1:0]  msk = 2'h0, step_up, step_dn;
   logic        busy, wrap_active, info_flag, alarm, home_set, irq;
   wrap_cfg_t   sensor_cfg;
   move_type_t  move_type;
   logic [63:0] exp_q[$];
   logic [63:0] nt;
   int          n_fail = 0, n_tests = 0, cyc = 0;
   logic [7:0]  da[12] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h20, 8'h30, 8'h34, 8'h40};
   logic [31:0] dv[12] = '{32'h0, 32'h0, 32'h1, 32'ha, 32'h1388, 32'h0, 32'h1, 32'h1, 32'h0, 32'h0, 32'h0, 32'h0};

   always #25 clk = ~clk;

   wrap_coordinate_generator dut (.clk(clk), .rst(rst), .ce(ce), .addr(addr), .wr_data(wr_data),
      .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .sensor_cfg(sensor_cfg),
      .small_frame(small_frame), .push_sel(push_sel), .step_up(step_up), .step_dn(step_dn),
      .cmd_pos(cmd_pos), .act_pos(act_pos), .move_type(move_type), .wrap_active(wrap_active),
      .info_flag(info_flag), .alarm(alarm), .home_set(home_set), .irq(irq));
   motion_partner partner (.clk(clk), .rst(rst), .go(go), .dir(dir), .mask(msk), .slow(slow),
      .step_up(step_up), .step_dn(step_dn), .busy(busy), .sensor_cfg(sensor_cfg));

   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction
   task automatic cmp(input logic [31:0] got, input logic [31:0] e, input logic [31:0] m);
      n_tests++;
      if ((got & m) !== (e & m))
      begin
         n_fail++;
         $display("BAD %0t got %h expected %h", $time, got, e);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr    <= a;
      wr_data <= d;
      wr_en   <= 1'b1;
      @(posedge clk);
      wr_en   <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
      @(posedge clk);
      addr  <= a;
      rd_en <= 1'b1;
      exp_q.push_back({e, m});
      @(posedge clk);
      rd_en <= 1'b0;
   endtask
   task automatic apply_cfg();
      wr(ADDR_CMD, 32'h1);
      repeat (4) @(posedge clk);
   endtask
   task automatic preset(input logic [31:0] h);
      wr(ADDR_HOME, h);
      wr(ADDR_CMD, 32'h2);
      repeat (3) @(posedge clk);
   endtask
   task automatic step(input logic up, input logic [1:0] m);
      int k;
      k = 0;
      @(posedge clk);
      go   <= 1'b1;
      dir  <= up;
      msk  <= m;
      slow <= ~slow;
      @(posedge clk);
      go <= 1'b0;
      do
      begin
         @(posedge clk);
         #1 k++;
      end while (busy !== 1'b0 && k < 10);
   endtask
   task automatic wrap_up();
      $display("tests %0d failures %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // read data stands only in the cycle after the strobe
   always @(posedge clk)
      rd_seen <= rd_en & ce;
   always @(negedge clk)
   begin
      if (rd_seen && exp_q.size() > 0)
      begin
         nt = exp_q.pop_front();
         cmp(rd_data, nt[63:32], nt[31:0]);
      end
   end
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         n_fail++;
         wrap_up();
      end
   end

   initial
   begin
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      for (int i = 0; i < 12; i++)
         rd(da[i], dv[i], 32'hffffffff);
      rd(ADDR_STATUS, 32'h8, 32'hf);
      for (int m = 0; m < 4; m++)
      begin
         seed = xs(seed);
         push_sel <= seed[0] ^ m[0];
         wr(ADDR_MODE, m);
         repeat (3) @(posedge clk);
         #1 cmp({29'h0, move_type}, {29'h0, seed[0] ^ m[0], m[1:0]}, 32'h7);
      end
      @(posedge clk);
      ce <= 1'b0;
      wr(ADDR_MODE, 32'h0);
      ce <= 1'b1;
      rd(ADDR_MODE, 32'h3, 32'h3);
      wr(ADDR_RATIO, 32'd12000);
      rd(ADDR_RATIO, 32'd10000, 32'hffffffff);
      wr(ADDR_OFFSET, 32'he0000000);
      rd(ADDR_OFFSET, 32'he0000000, 32'hffffffff);
      wr(ADDR_OFFSET, 32'h0);
      wr(ADDR_RATIO, 32'd5000);
      wr(ADDR_RANGE, 32'd10000);
      apply_cfg();
      rd(ADDR_STATUS, 32'h8, 32'hb);
      wr(ADDR_SRC, 32'h1);
      apply_cfg();
      rd(ADDR_STATUS, 32'h3, 32'hb);
      wr(ADDR_RANGE, 32'd5);
      wr(ADDR_GEAR_A, 32'd3);
      apply_cfg();
      preset(32'hfffffcbf);
      rd(ADDR_STATUS, 32'h5, 32'hd);
      step(1'b0, 2'h1);
      rd(ADDR_CMD_POS, 32'hfffffcbe, 32'hffffffff);
      wr(ADDR_RANGE, 32'd10);
      wr(ADDR_GEAR_A, 32'd1);
      apply_cfg();
      apply_cfg();
      rd(ADDR_STATUS, 32'hc, 32'hf);
      #1 cmp({28'h0, wrap_active, home_set, alarm, info_flag}, 32'hc, 32'hf);
      preset(32'd4999);
      rd(ADDR_ACT_POS, 32'd4999, 32'hffffffff);
      step(1'b1, 2'h3);
      rd(ADDR_CMD_POS, 32'hffffec78, 32'hffffffff);
      rd(ADDR_ACT_POS, 32'hffffec78, 32'hffffffff);
      step(1'b0, 2'h1);
      rd(ADDR_CMD_POS, 32'd4999, 32'hffffffff);
      wr(ADDR_OFFSET, 32'd100);
      apply_cfg();
      preset(32'd5099);
      step(1'b1, 2'h1);
      rd(ADDR_CMD_POS, 32'hffffecdc, 32'hffffffff);
      wr(ADDR_HOME, 32'hffffec78);
      repeat (3) @(posedge clk);
      rd(ADDR_STATUS, 32'h1, 32'h1);
      wr(ADDR_HOME, 32'h0);
      small_frame <= 1'b1;
      wr(ADDR_RANGE, 32'd18000);
      apply_cfg();
      apply_cfg();
      rd(ADDR_STATUS, 32'h7, 32'hf);
      #1 cmp({28'h0, wrap_active, home_set, alarm, info_flag}, 32'h7, 32'hf);
      rd(ADDR_INT_STAT, 32'hf, 32'hf);
      wr(ADDR_INT_EN, 32'hf);
      repeat (3) @(posedge clk);
      #1 cmp({31'h0, irq}, 32'h1, 32'h1);
      wr(ADDR_INT_CLR, 32'hf);
      wr(ADDR_INT_EN, 32'h0);
      repeat (3) @(posedge clk);
      #1 cmp({31'h0, irq}, 32'h0, 32'h1);
      rd(ADDR_INT_STAT, 32'h0, 32'hf);
      preset(32'h0);
      #1 cmp({31'h0, irq}, 32'h0, 32'h1);
      rd(ADDR_INT_STAT, 32'h8, 32'h8);
      wr(ADDR_INT_EN, 32'h8);
      repeat (3) @(posedge clk);
      #1 cmp({31'h0, irq}, 32'h1, 32'h1);
      wr(ADDR_INT_CLR, 32'h8);
      repeat (3) @(posedge clk);
      #1 cmp({31'h0, irq}, 32'h0, 32'h1);
      repeat (4) @(posedge clk);
      if (exp_q.size() != 0)
         n_fail++;
      wrap_up();
   end
endmodule
